// *** rtl/dword_shift_register_map.svh ***
`ifndef DWORD_SHIFT_REGISTER_MAP_SVH
`define DWORD_SHIFT_REGISTER_MAP_SVH

// shape of the shift register
`define SR_STAGES        8
`define SR_WORD_W        32
`define SR_BUF_DEPTH     2

// avalon register map, byte addresses
`define SR_ADDR_W        8
`define SR_OFF_CTRL      8'h00
`define SR_OFF_STATUS    8'h04
`define SR_OFF_STAGE0    8'h20
`define SR_OFF_STAGE7    8'h3C

// control register fields and reset value
`define SR_CTRL_EN_BIT   0
`define SR_CTRL_CLR_BIT  1
`define SR_CTRL_RESET    32'h0000_0001

// status register fields
`define SR_STAT_CNT_LSB  0
`define SR_STAT_DROP_BIT 4
`define SR_STAT_EN_BIT   5

`endif

// *** rtl/dword_shift_register_pkg.sv ***
package dword_shift_register_pkg;
  `include "dword_shift_register_map.svh"

  typedef logic signed [`SR_WORD_W-1:0] dword_t;

  // one queued shift: direction and the word captured at the strobe edge
  typedef struct packed {
    logic   backward;
    dword_t word;
  } shift_req_t;

  // word pushed out of the far end by a shift
  typedef struct packed {
    logic   fromStageEight;
    dword_t word;
  } drop_word_t;

  typedef logic [`SR_STAGES-1:0][`SR_WORD_W-1:0] stage_bank_t;
endpackage

// *** rtl/dword_shift_register.sv ***
// Overview of operation
// - forward edge loads stage one, shifts up
// - backward edge loads stage eight, shifts down
// - enable inactive blocks all shifting
// - clear input zeroes every stage
// - stages and inputs are signed 32-bit
// - all eight stages always on outputs
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module dword_shift_register
  import dword_shift_register_pkg::*;
#(
  parameter int DEPTH = `SR_BUF_DEPTH
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  clkEn,
  input  wire logic                  forwardShiftStrobe,
  input  wire logic                  backwardShiftStrobe,
  input  wire logic                  blockEnableCoil,
  input  wire logic                  registerClearCoil,
  input  wire dword_t                forwardInputWord,
  input  wire dword_t                backwardInputWord,
  output      stage_bank_t           stageWords,
  output      logic                  shiftReady,
  output      drop_word_t            dropWord,
  output      logic                  dropValid,
  input  wire logic                  dropReady,
  input  wire logic [`SR_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output      logic [31:0]           avs_readdata,
  output      logic                  avs_waitrequest
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // input synchronisers: meta flop feeds only the sync flop
  logic [3:0] ctlMeta_ff, ctlSync_ff, ctlPrev_ff;
  dword_t     fwdMeta_ff, fwdSync_ff, bwdMeta_ff, bwdSync_ff;
  logic [3:0] nxt_ctlMeta, nxt_ctlSync, nxt_ctlPrev;
  dword_t     nxt_fwdMeta, nxt_fwdSync, nxt_bwdMeta, nxt_bwdSync;

  always_comb begin
    nxt_ctlMeta = ctlMeta_ff;
    nxt_ctlSync = ctlSync_ff;
    nxt_ctlPrev = ctlPrev_ff;
    nxt_fwdMeta = fwdMeta_ff;
    nxt_fwdSync = fwdSync_ff;
    nxt_bwdMeta = bwdMeta_ff;
    nxt_bwdSync = bwdSync_ff;
    if (clkEn) begin
      nxt_ctlMeta = {registerClearCoil, blockEnableCoil, backwardShiftStrobe, forwardShiftStrobe};
      nxt_ctlSync = ctlMeta_ff;
      nxt_ctlPrev = ctlSync_ff;
      nxt_fwdMeta = forwardInputWord;
      nxt_fwdSync = fwdMeta_ff;
      nxt_bwdMeta = backwardInputWord;
      nxt_bwdSync = bwdMeta_ff;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctlMeta_ff <= 4'h0;
      ctlSync_ff <= 4'h0;
      ctlPrev_ff <= 4'h0;
      fwdMeta_ff <= 32'sh0;
      fwdSync_ff <= 32'sh0;
      bwdMeta_ff <= 32'sh0;
      bwdSync_ff <= 32'sh0;
    end else begin
      ctlMeta_ff <= nxt_ctlMeta;
      ctlSync_ff <= nxt_ctlSync;
      ctlPrev_ff <= nxt_ctlPrev;
      fwdMeta_ff <= nxt_fwdMeta;
      fwdSync_ff <= nxt_fwdSync;
      bwdMeta_ff <= nxt_bwdMeta;
      bwdSync_ff <= nxt_bwdSync;
    end
  end

  // control register bits, drive the block alongside the coils
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic        effEn, clearNow, fwdEdge, bwdEdge;
  assign effEn    = ctlSync_ff[2] & ctrl_ff[`SR_CTRL_EN_BIT];
  assign clearNow = ctlSync_ff[3] | ctrl_ff[`SR_CTRL_CLR_BIT];
  assign fwdEdge  = ctlSync_ff[0] & ~ctlPrev_ff[0];
  assign bwdEdge  = ctlSync_ff[1] & ~ctlPrev_ff[1];

  // two-entry request buffer between strobe edges and the shifter
  shift_req_t     reqMem_ff [DEPTH];
  shift_req_t     nxt_reqMem [DEPTH];
  logic [PW-1:0]  wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
  logic [CW-1:0]  count_ff, nxt_count;
  logic           pushReq, popReq, reqValid;
  shift_req_t     pushData, headReq;
  drop_word_t     drop_ff, nxt_drop;
  logic           dropValid_ff, nxt_dropValid;
  stage_bank_t    stage_ff, nxt_stage;

  assign reqValid   = (count_ff != '0);
  assign shiftReady = (count_ff != CW'(DEPTH));
  assign headReq    = reqMem_ff[rdPtr_ff];
  assign pushReq    = clkEn & effEn & ~clearNow & (fwdEdge | bwdEdge) & shiftReady;
  assign pushData   = fwdEdge ? '{backward: 1'b0, word: fwdSync_ff}
                              : '{backward: 1'b1, word: bwdSync_ff};
  // the shifter stalls while the drop slot is full and not taken
  assign popReq     = clkEn & effEn & ~clearNow & reqValid & (~dropValid_ff | dropReady);

  always_comb begin
    nxt_reqMem = reqMem_ff;
    nxt_wrPtr  = wrPtr_ff;
    nxt_rdPtr  = rdPtr_ff;
    nxt_count  = count_ff;
    if (pushReq) begin
      nxt_reqMem[wrPtr_ff] = pushData;
      nxt_wrPtr = (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
    end
    if (popReq) begin
      nxt_rdPtr = (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1);
    end
    if (pushReq && !popReq) begin
      nxt_count = count_ff + CW'(1);
    end else if (popReq && !pushReq) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        reqMem_ff[i] <= '0;
      end
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      reqMem_ff <= nxt_reqMem;
      wrPtr_ff  <= nxt_wrPtr;
      rdPtr_ff  <= nxt_rdPtr;
      count_ff  <= nxt_count;
    end
  end

  // stage bank and drop slot
  always_comb begin
    nxt_stage     = stage_ff;
    nxt_drop      = drop_ff;
    nxt_dropValid = dropValid_ff;
    if (clkEn && dropValid_ff && dropReady) begin
      nxt_dropValid = 1'b0;
    end
    if (clkEn && clearNow) begin
      nxt_stage = '0;
    end else if (popReq && !headReq.backward) begin
      nxt_drop      = '{fromStageEight: 1'b1, word: stage_ff[`SR_STAGES-1]};
      nxt_dropValid = 1'b1;
      nxt_stage     = {stage_ff[`SR_STAGES-2:0], headReq.word};
    end else if (popReq) begin
      nxt_drop      = '{fromStageEight: 1'b0, word: stage_ff[0]};
      nxt_dropValid = 1'b1;
      nxt_stage     = {headReq.word, stage_ff[`SR_STAGES-1:1]};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_ff     <= '0;
      drop_ff      <= '0;
      dropValid_ff <= 1'b0;
    end else begin
      stage_ff     <= nxt_stage;
      drop_ff      <= nxt_drop;
      dropValid_ff <= nxt_dropValid;
    end
  end

  assign stageWords = stage_ff;
  assign dropWord   = drop_ff;
  assign dropValid  = dropValid_ff;

  // avalon slave: one wait cycle, then answer
  logic        ack_ff, nxt_ack, busReq;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [2:0]  stageIdx;
  assign busReq          = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign stageIdx        = 3'(avs_address[4:2]);

  always_comb begin
    nxt_ack   = ack_ff;
    nxt_rdata = rdata_ff;
    nxt_ctrl  = ctrl_ff;
    if (clkEn) begin
      nxt_ack = busReq & ~ack_ff;
      nxt_ctrl[`SR_CTRL_CLR_BIT] = 1'b0;
      if (avs_read && !ack_ff) begin
        nxt_rdata = 32'h0;
        if (avs_address == `SR_OFF_CTRL) begin
          nxt_rdata = ctrl_ff;
        end else if (avs_address == `SR_OFF_STATUS) begin
          nxt_rdata[`SR_STAT_CNT_LSB +: CW] = count_ff;
          nxt_rdata[`SR_STAT_DROP_BIT]      = dropValid_ff;
          nxt_rdata[`SR_STAT_EN_BIT]        = effEn;
        end else if (avs_address >= `SR_OFF_STAGE0 && avs_address <= `SR_OFF_STAGE7
                     && avs_address[1:0] == 2'h0) begin
          nxt_rdata = stage_ff[stageIdx];
        end
      end
      if (avs_write && ack_ff && avs_address == `SR_OFF_CTRL) begin
        nxt_ctrl[`SR_CTRL_EN_BIT]  = avs_writedata[`SR_CTRL_EN_BIT];
        nxt_ctrl[`SR_CTRL_CLR_BIT] = avs_writedata[`SR_CTRL_CLR_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
      ctrl_ff  <= `SR_CTRL_RESET;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
      ctrl_ff  <= nxt_ctrl;
    end
  end

  // checks
  property p_fwd_load;
    @(posedge core_clk) disable iff (!reset_n)
    (popReq && !clearNow && !headReq.backward) |=> (stage_ff[0] == $past(headReq.word));
  endproperty
  a_fwd_load: assert property (p_fwd_load) else $error("forward shift did not load stage one");

  property p_bwd_load;
    @(posedge core_clk) disable iff (!reset_n)
    (popReq && headReq.backward) |=> (stage_ff[`SR_STAGES-1] == $past(headReq.word));
  endproperty
  a_bwd_load: assert property (p_bwd_load) else $error("backward shift did not load stage eight");

  property p_fwd_drop;
    @(posedge core_clk) disable iff (!reset_n)
    (popReq && !headReq.backward) |=> (stage_ff[`SR_STAGES-1] == $past(stage_ff[`SR_STAGES-2]))
      && dropValid_ff && (drop_ff.word == $past(stage_ff[`SR_STAGES-1]));
  endproperty
  a_fwd_drop: assert property (p_fwd_drop) else $error("forward shift moved words wrongly");

  property p_bwd_drop;
    @(posedge core_clk) disable iff (!reset_n)
    (popReq && headReq.backward) |=> (stage_ff[0] == $past(stage_ff[1]))
      && (drop_ff.word == $past(stage_ff[0]));
  endproperty
  a_bwd_drop: assert property (p_bwd_drop) else $error("backward shift moved words wrongly");

  property p_disabled;
    @(posedge core_clk) disable iff (!reset_n)
    (!effEn && !clearNow) |=> $stable(stage_ff) && $stable(count_ff);
  endproperty
  a_disabled: assert property (p_disabled) else $error("shift while block disabled");

  property p_clear;
    @(posedge core_clk) disable iff (!reset_n)
    (clkEn && clearNow) |=> (stage_ff == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a stage nonzero");

  property p_signed;
    @(posedge core_clk) disable iff (!reset_n)
    (popReq && !headReq.backward && headReq.word < 0) |=> (stageWords[0][`SR_WORD_W-1]);
  endproperty
  a_signed: assert property (p_signed) else $error("negative word lost its sign");

  property p_outputs;
    @(posedge core_clk) disable iff (!reset_n)
    (!popReq && !(clkEn && clearNow)) |=> $stable(stageWords);
  endproperty
  a_outputs: assert property (p_outputs) else $error("stage outputs changed without cause");

  property p_edge_to_shift;
    @(posedge core_clk) disable iff (!reset_n)
    (pushReq && count_ff == '0 && !dropValid_ff && dropReady) ##1 (clkEn && effEn && !clearNow)
      |-> popReq;
  endproperty
  a_edge_to_shift: assert property (p_edge_to_shift) else $error("queued shift not executed");

  c_fwd: cover property (@(posedge core_clk) disable iff (!reset_n)
    popReq && !headReq.backward);
  c_bwd: cover property (@(posedge core_clk) disable iff (!reset_n)
    popReq && headReq.backward);
  c_full: cover property (@(posedge core_clk) disable iff (!reset_n)
    !shiftReady && dropValid_ff && !dropReady);
  c_clear: cover property (@(posedge core_clk) disable iff (!reset_n)
    clkEn && clearNow && stage_ff != '0);
endmodule

// *** testbench/dword_shift_host_model.sv ***
`timescale 1ns/1ps
module dword_shift_host_model
  import dword_shift_register_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   stall,
  output      logic   forwardShiftStrobe,
  output      logic   backwardShiftStrobe,
  output      dword_t forwardInputWord,
  output      dword_t backwardInputWord,
  output      logic   dropReady
);
  assign dropReady = !stall;

  initial begin
    forwardShiftStrobe  = 1'b0;
    backwardShiftStrobe = 1'b0;
    forwardInputWord    = 32'h0000_0000;
    backwardInputWord   = 32'h0000_0000;
  end

  // word stands from a cycle before the rise to two cycles after the fall, then scrambles
  task automatic pulse(input logic bwd, input dword_t w);
    if (bwd) backwardInputWord <= w;
    else forwardInputWord <= w;
    @(posedge core_clk);
    if (bwd) backwardShiftStrobe <= 1'b1;
    else forwardShiftStrobe <= 1'b1;
    repeat (2) @(posedge core_clk);
    backwardShiftStrobe <= 1'b0;
    forwardShiftStrobe  <= 1'b0;
    repeat (2) @(posedge core_clk);
    if (bwd) backwardInputWord <= ~w;
    else forwardInputWord <= ~w;
    @(posedge core_clk);
  endtask
endmodule

// *** testbench/dword_shift_register_tb_top.sv ***
`timescale 1ns/1ps
module dword_shift_register_tb_top
  import dword_shift_register_pkg::*;
;
  logic        core_clk, reset_n, blockEnableCoil, registerClearCoil, stall, clkEn;
  logic        avs_read, avs_write, avs_waitrequest, shiftReady, dropValid, dropReady;
  logic        forwardShiftStrobe, backwardShiftStrobe;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  dword_t      forwardInputWord, backwardInputWord, w;
  dword_t      expStage [8];
  stage_bank_t stageWords;
  drop_word_t  dropWord, expDrop;
  int          n_fail, n_tests;

  dword_shift_register dut_u (.core_clk, .reset_n, .clkEn, .forwardShiftStrobe,
    .backwardShiftStrobe, .blockEnableCoil, .registerClearCoil, .forwardInputWord,
    .backwardInputWord, .stageWords, .shiftReady, .dropWord, .dropValid, .dropReady,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

  dword_shift_host_model host_u (.core_clk, .stall, .forwardShiftStrobe, .backwardShiftStrobe,
    .forwardInputWord, .backwardInputWord, .dropReady);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task chk(input logic [32:0] got, input logic [32:0] want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0000_0000);
    chk({1'b0, rd}, {1'b0, want});
  endtask

  // reference shift: update expected stages and the word pushed out
  task shf(input logic bwd, input dword_t v);
    expDrop = bwd ? {1'b0, expStage[0]} : {1'b1, expStage[7]};
    for (int i = 0; i < 7; i++) begin
      if (bwd) expStage[i] = expStage[i+1];
      else expStage[7-i] = expStage[6-i];
    end
    expStage[bwd ? 7 : 0] = v;
  endtask

  task go(input logic bwd, input dword_t v);
    host_u.pulse(bwd, v);
    shf(bwd, v);
  endtask

  task stages;
    for (int i = 0; i < 8; i++) chk({1'b0, stageWords[i]}, {1'b0, expStage[i]});
  endtask

  task endt(input string s);
    $display("test %s end", s);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    n_fail++;
    stop_test;
  end

  initial begin
    reset_n = 1'b0;
    blockEnableCoil = 1'b1;
    registerClearCoil = 1'b0;
    stall = 1'b0;
    clkEn = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    n_fail = 0;
    n_tests = 0;
    expStage = '{default: '0};
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rdchk(8'h00, 32'h0000_0001);
    rdchk(8'h04, 32'h0000_0020);
    stages;
    endt("reset");
    for (int i = 0; i < 9; i++) begin
      w = (i == 1) ? 32'h7FFF_FFFF : 32'h8000_0000 + i * 32'h0135_79BD;
      go(1'b0, w);
    end
    stages;
    rdchk(8'h20, expStage[0]);
    rdchk(8'h3C, expStage[7]);
    endt("forward");
    go(1'b1, 32'h0000_000A);
    go(1'b1, 32'h0000_0034);
    go(1'b1, 32'hFFFF_FFFF);
    stages;
    endt("backward");
    blockEnableCoil <= 1'b0;
    repeat (3) @(posedge core_clk);
    host_u.pulse(1'b0, 32'h5A5A_0001);
    stages;
    rdchk(8'h04, 32'h0000_0000);
    blockEnableCoil <= 1'b1;
    bus(1'b1, 8'h00, 32'h0000_0000);
    host_u.pulse(1'b1, 32'h5A5A_0002);
    stages;
    bus(1'b1, 8'h00, 32'h0000_0001);
    clkEn <= 1'b0;
    host_u.pulse(1'b1, 32'h5A5A_0003);
    clkEn <= 1'b1;
    repeat (4) @(posedge core_clk);
    stages;
    endt("disable");
    stall <= 1'b1;
    go(1'b0, 32'h1111_1111);
    chk(dropWord, expDrop);
    host_u.pulse(1'b0, 32'h2222_2222);
    host_u.pulse(1'b0, 32'h3333_3333);
    host_u.pulse(1'b0, 32'h4444_4444);
    chk({32'h0, shiftReady}, 33'h0);
    rdchk(8'h04, 32'h0000_0032);
    stages;
    stall <= 1'b0;
    repeat (10) @(posedge core_clk);
    shf(1'b0, 32'h2222_2222);
    shf(1'b0, 32'h3333_3333);
    stages;
    chk({32'h0, shiftReady}, 33'h1);
    endt("stall");
    registerClearCoil <= 1'b1;
    repeat (4) @(posedge core_clk);
    registerClearCoil <= 1'b0;
    repeat (3) @(posedge core_clk);
    expStage = '{default: '0};
    stages;
    go(1'b0, 32'h0000_0077);
    bus(1'b1, 8'h00, 32'h0000_0003);
    repeat (2) @(posedge core_clk);
    expStage = '{default: '0};
    stages;
    rdchk(8'h00, 32'h0000_0001);
    endt("clear");
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'h0000_0000);
    bus(1'b1, 8'h20, 32'h1234_5678);
    rdchk(8'h20, expStage[0]);
    endt("bus");
    stop_test;
  end
endmodule
